/* File: hw/sxl_core.sv */
// Function
// - OR memory into selected accumulator
// - OR sets N, Z, clears V
// - OR operand immediate, direct, indexed, extended
// - OR immediate byte into condition codes
// - Mask byte selects any register subset
// - Push tests mask bit seven downward
// - Decrement first; low byte before high
// - Hardware push never stores own pointer
// - Pull tests bit zero upward, post-increment
// - Second stack pull never reloads itself
// - Only pulled condition codes change flags
// - Rotate left through carry, V=b7^b6
// - Rotate right through carry, V kept
// - Rotate accumulator or direct/indexed/extended memory
// - Return pulls codes, then full state when entire flag set
// - Entire flag clear: pull program counter only
// - Exception stacking sets entire flag first
`include "sxl_map.svh"

module sxl_core (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // APB register port
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Byte memory port
   output sxl_pkg::sxl_mem_req_type mem_out,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_ack
);

   sxl_pkg::sxl_state_type state_q;
   sxl_pkg::sxl_op_type op_q;
   sxl_pkg::sxl_mem_req_type mem_q;
   logic [15:0] ea_q;
   logic [11:0] pending_q;
   logic pull_q;
   logic use_u_q;
   logic rti_first_q;
   logic [31:0] prdata_q;
   logic [7:0] a_q, b_q, dp_q, cc_q;
   logic [15:0] x_q, y_q, u_q, s_q, pc_q;

   logic apb_acc;
   logic busy;
   logic err;
   logic cmd_ok;
   logic start;
   logic reg_wr;
   logic mem_done;
   sxl_pkg::sxl_op_type cmd_op;
   sxl_pkg::sxl_mode_type cmd_mode;
   logic [7:0] cmd_imm;
   logic [15:0] cmd_ea;
   logic [11:0] cmd_pending;
   logic [11:0] pending_left;
   logic [15:0] ptr;
   logic [15:0] other;
   logic [15:0] ptr_step;
   logic [7:0] slot_byte;
   logic pick_found;
   logic [3:0] pick_slot;
   sxl_pkg::sxl_op_type alu_op;
   logic [7:0] alu_a;
   logic [7:0] alu_b;
   sxl_pkg::sxl_alu_out_type alu_res;

   // APB decode
   assign apb_acc = psel & penable;
   assign pready = apb_acc;
   assign pslverr = apb_acc & err;
   assign prdata = prdata_q;
   assign busy = (state_q != sxl_pkg::st_idle);
   assign start = apb_acc & pwrite & ~err & (paddr == `SXL_OFF_CMD);
   assign reg_wr = apb_acc & pwrite & ~err & (paddr != `SXL_OFF_CMD);
   assign mem_done = mem_q.req & mem_ack;
   assign mem_out = mem_q;

   assign cmd_op = sxl_pkg::sxl_op_type'(pwdata[`SXL_CMD_OP_MSB:`SXL_CMD_OP_LSB]);
   assign cmd_mode = sxl_pkg::sxl_mode_type'(pwdata[`SXL_CMD_MODE_MSB:`SXL_CMD_MODE_LSB]);
   assign cmd_imm = pwdata[`SXL_CMD_IMM_MSB:`SXL_CMD_IMM_LSB];

   // Mask bit 7 covers the first two push slots, bit 0 the last
   assign cmd_pending = {cmd_imm[0], cmd_imm[1], cmd_imm[2], cmd_imm[3], cmd_imm[4], cmd_imm[4],
                         cmd_imm[5], cmd_imm[5], cmd_imm[6], cmd_imm[6], cmd_imm[7], cmd_imm[7]};

   always_comb begin
      unique case (cmd_mode)
         sxl_pkg::mode_direct: cmd_ea = {dp_q, cmd_imm};
         sxl_pkg::mode_indexed: cmd_ea = x_q + {{8{cmd_imm[7]}}, cmd_imm};
         sxl_pkg::mode_extended: cmd_ea = pwdata[`SXL_CMD_EXT_MSB:`SXL_CMD_EXT_LSB];
         sxl_pkg::mode_immediate: cmd_ea = 16'h0000;
      endcase
   end

   always_comb begin
      case (cmd_op)
         sxl_pkg::op_rotate_left_nine_bit_mem, sxl_pkg::op_rotate_right_nine_bit_mem:
            cmd_ok = (cmd_mode != sxl_pkg::mode_immediate);
         sxl_pkg::op_or_into_accumulator_a, sxl_pkg::op_or_into_accumulator_b,
         sxl_pkg::op_or_condition_codes, sxl_pkg::op_push_hardware_stack,
         sxl_pkg::op_push_second_stack, sxl_pkg::op_pull_hardware_stack,
         sxl_pkg::op_pull_second_stack, sxl_pkg::op_rotate_left_nine_bit_a,
         sxl_pkg::op_rotate_left_nine_bit_b, sxl_pkg::op_rotate_right_nine_bit_a,
         sxl_pkg::op_rotate_right_nine_bit_b, sxl_pkg::op_return_from_interrupt,
         sxl_pkg::op_exception_stack:
            cmd_ok = 1'b1;
         default:
            cmd_ok = 1'b0;
      endcase
   end

   always_comb begin
      case (paddr)
         `SXL_OFF_CMD: err = pwrite & (busy | ~cmd_ok);
         `SXL_OFF_STAT: err = pwrite;
         `SXL_OFF_ACC, `SXL_OFF_IDX, `SXL_OFF_STK, `SXL_OFF_PC: err = pwrite & busy;
         default: err = 1'b1;
      endcase
   end

   // ALU operands: command word while idle, fetched byte afterwards
   assign alu_op = busy ? op_q : cmd_op;
   assign alu_b = busy ? mem_rdata : cmd_imm;
   always_comb begin
      case (alu_op)
         sxl_pkg::op_or_into_accumulator_b, sxl_pkg::op_rotate_left_nine_bit_b,
         sxl_pkg::op_rotate_right_nine_bit_b: alu_a = b_q;
         sxl_pkg::op_rotate_left_nine_bit_mem, sxl_pkg::op_rotate_right_nine_bit_mem: alu_a = mem_rdata;
         default: alu_a = a_q;
      endcase
   end

   sxl_alu u_alu (
      .op(alu_op),
      .opa(alu_a),
      .opb(alu_b),
      .cc(cc_q),
      .res(alu_res)
   );

   sxl_slot_pick #(.SLOTS(12)) u_pick (
      .pending(pending_q),
      .pull(pull_q),
      .found(pick_found),
      .slot(pick_slot)
   );

   // Active pointer and the opposite stack pointer
   assign ptr = use_u_q ? u_q : s_q;
   assign other = use_u_q ? s_q : u_q;
   assign ptr_step = pull_q ? ptr + 16'h0001 : ptr - 16'h0001;
   assign pending_left = pending_q & ~(12'h001 << pick_slot);

   always_comb begin
      unique case (pick_slot)
         `SXL_SLOT_PCL: slot_byte = pc_q[7:0];
         `SXL_SLOT_PCH: slot_byte = pc_q[15:8];
         `SXL_SLOT_OSL: slot_byte = other[7:0];
         `SXL_SLOT_OSH: slot_byte = other[15:8];
         `SXL_SLOT_YL: slot_byte = y_q[7:0];
         `SXL_SLOT_YH: slot_byte = y_q[15:8];
         `SXL_SLOT_XL: slot_byte = x_q[7:0];
         `SXL_SLOT_XH: slot_byte = x_q[15:8];
         `SXL_SLOT_DP: slot_byte = dp_q;
         `SXL_SLOT_B: slot_byte = b_q;
         `SXL_SLOT_A: slot_byte = a_q;
         default: slot_byte = cc_q;
      endcase
   end

   // Read data is captured in the setup phase
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prdata_q <= 32'h00000000;
      end else if (psel && !penable) begin
         case (paddr)
            `SXL_OFF_CMD: prdata_q <= {ea_q, 11'h000, op_q};
            `SXL_OFF_STAT: prdata_q <= {19'h00000, pending_q, busy};
            `SXL_OFF_ACC: prdata_q <= {cc_q, dp_q, b_q, a_q};
            `SXL_OFF_IDX: prdata_q <= {y_q, x_q};
            `SXL_OFF_STK: prdata_q <= {s_q, u_q};
            `SXL_OFF_PC: prdata_q <= {16'h0000, pc_q};
            default: prdata_q <= 32'h00000000;
         endcase
      end
   end

   // Sequencer and memory request
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q <= sxl_pkg::st_idle;
         op_q <= sxl_pkg::op_or_into_accumulator_a;
         mem_q <= '0;
         ea_q <= 16'h0000;
         pending_q <= 12'h000;
         pull_q <= 1'b0;
         use_u_q <= 1'b0;
         rti_first_q <= 1'b0;
      end else if (start) begin
         op_q <= cmd_op;
         ea_q <= cmd_ea;
         pull_q <= 1'b0;
         use_u_q <= 1'b0;
         rti_first_q <= 1'b0;
         pending_q <= 12'h000;
         case (cmd_op)
            sxl_pkg::op_or_into_accumulator_a, sxl_pkg::op_or_into_accumulator_b: begin
               if (cmd_mode != sxl_pkg::mode_immediate) begin
                  state_q <= sxl_pkg::st_read;
               end
            end
            sxl_pkg::op_rotate_left_nine_bit_mem, sxl_pkg::op_rotate_right_nine_bit_mem: begin
               state_q <= sxl_pkg::st_read;
            end
            sxl_pkg::op_push_hardware_stack, sxl_pkg::op_push_second_stack,
            sxl_pkg::op_pull_hardware_stack, sxl_pkg::op_pull_second_stack: begin
               pending_q <= cmd_pending;
               pull_q <= (cmd_op == sxl_pkg::op_pull_hardware_stack) ||
                         (cmd_op == sxl_pkg::op_pull_second_stack);
               use_u_q <= (cmd_op == sxl_pkg::op_push_second_stack) ||
                          (cmd_op == sxl_pkg::op_pull_second_stack);
               if (cmd_imm != 8'h00) begin
                  state_q <= sxl_pkg::st_stack;
               end
            end
            sxl_pkg::op_return_from_interrupt: begin
               pending_q <= `SXL_SLOTS_CC;
               pull_q <= 1'b1;
               rti_first_q <= 1'b1;
               state_q <= sxl_pkg::st_stack;
            end
            sxl_pkg::op_exception_stack: begin
               pending_q <= `SXL_SLOTS_ALL;
               state_q <= sxl_pkg::st_stack;
            end
            default: begin
            end
         endcase
      end else begin
         unique case (state_q)
            sxl_pkg::st_idle: begin
            end
            sxl_pkg::st_read: begin
               if (!mem_q.req) begin
                  mem_q.req <= 1'b1;
                  mem_q.we <= 1'b0;
                  mem_q.addr <= ea_q;
               end else if (mem_ack) begin
                  mem_q.req <= 1'b0;
                  if (op_q == sxl_pkg::op_rotate_left_nine_bit_mem ||
                      op_q == sxl_pkg::op_rotate_right_nine_bit_mem) begin
                     mem_q.wdata <= alu_res.value;
                     state_q <= sxl_pkg::st_write;
                  end else begin
                     state_q <= sxl_pkg::st_idle;
                  end
               end
            end
            sxl_pkg::st_write: begin
               if (!mem_q.req) begin
                  mem_q.req <= 1'b1;
                  mem_q.we <= 1'b1;
                  mem_q.addr <= ea_q;
               end else if (mem_ack) begin
                  mem_q.req <= 1'b0;
                  state_q <= sxl_pkg::st_idle;
               end
            end
            sxl_pkg::st_stack: begin
               if (!mem_q.req) begin
                  mem_q.req <= pick_found;
                  mem_q.we <= ~pull_q;
                  mem_q.addr <= pull_q ? ptr : ptr_step;
                  mem_q.wdata <= slot_byte;
               end else if (mem_ack) begin
                  mem_q.req <= 1'b0;
                  pending_q <= pending_left;
                  if (pending_left == 12'h000) begin
                     if (rti_first_q) begin
                        rti_first_q <= 1'b0;
                        pending_q <= mem_rdata[`SXL_CC_E] ? `SXL_SLOTS_NO_CC : `SXL_SLOTS_PC;
                     end else begin
                        state_q <= sxl_pkg::st_idle;
                     end
                  end
               end
            end
         endcase
      end
   end

   // Programmer model registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         a_q <= `SXL_RST_BYTE;
         b_q <= `SXL_RST_BYTE;
         dp_q <= `SXL_RST_BYTE;
         cc_q <= `SXL_RST_CC;
         x_q <= `SXL_RST_WORD;
         y_q <= `SXL_RST_WORD;
         u_q <= `SXL_RST_WORD;
         s_q <= `SXL_RST_WORD;
         pc_q <= `SXL_RST_WORD;
      end else if (reg_wr) begin
         case (paddr)
            `SXL_OFF_ACC: begin
               a_q <= pwdata[7:0];
               b_q <= pwdata[15:8];
               dp_q <= pwdata[23:16];
               cc_q <= pwdata[31:24];
            end
            `SXL_OFF_IDX: begin
               x_q <= pwdata[15:0];
               y_q <= pwdata[31:16];
            end
            `SXL_OFF_STK: begin
               u_q <= pwdata[15:0];
               s_q <= pwdata[31:16];
            end
            `SXL_OFF_PC: pc_q <= pwdata[15:0];
            default: begin
            end
         endcase
      end else if (start) begin
         case (cmd_op)
            sxl_pkg::op_or_into_accumulator_a, sxl_pkg::op_rotate_left_nine_bit_a,
            sxl_pkg::op_rotate_right_nine_bit_a: begin
               if (cmd_mode == sxl_pkg::mode_immediate || cmd_op != sxl_pkg::op_or_into_accumulator_a) begin
                  a_q <= alu_res.value;
                  cc_q <= alu_res.cc;
               end
            end
            sxl_pkg::op_or_into_accumulator_b, sxl_pkg::op_rotate_left_nine_bit_b,
            sxl_pkg::op_rotate_right_nine_bit_b: begin
               if (cmd_mode == sxl_pkg::mode_immediate || cmd_op != sxl_pkg::op_or_into_accumulator_b) begin
                  b_q <= alu_res.value;
                  cc_q <= alu_res.cc;
               end
            end
            sxl_pkg::op_or_condition_codes: cc_q <= alu_res.cc;
            sxl_pkg::op_exception_stack: cc_q[`SXL_CC_E] <= 1'b1;
            default: begin
            end
         endcase
      end else if (mem_done && state_q == sxl_pkg::st_read) begin
         case (op_q)
            sxl_pkg::op_or_into_accumulator_a: a_q <= alu_res.value;
            sxl_pkg::op_or_into_accumulator_b: b_q <= alu_res.value;
            default: begin
            end
         endcase
         cc_q <= alu_res.cc;
      end else if (mem_done && state_q == sxl_pkg::st_stack) begin
         if (use_u_q) begin
            u_q <= ptr_step;
         end else begin
            s_q <= ptr_step;
         end
         if (pull_q) begin
            // Pushes never touch the flags; pulls only via the CC slot
            unique case (pick_slot)
               `SXL_SLOT_PCL: pc_q[7:0] <= mem_rdata;
               `SXL_SLOT_PCH: pc_q[15:8] <= mem_rdata;
               `SXL_SLOT_OSL: begin
                  if (use_u_q) s_q[7:0] <= mem_rdata;
                  else u_q[7:0] <= mem_rdata;
               end
               `SXL_SLOT_OSH: begin
                  if (use_u_q) s_q[15:8] <= mem_rdata;
                  else u_q[15:8] <= mem_rdata;
               end
               `SXL_SLOT_YL: y_q[7:0] <= mem_rdata;
               `SXL_SLOT_YH: y_q[15:8] <= mem_rdata;
               `SXL_SLOT_XL: x_q[7:0] <= mem_rdata;
               `SXL_SLOT_XH: x_q[15:8] <= mem_rdata;
               `SXL_SLOT_DP: dp_q <= mem_rdata;
               `SXL_SLOT_B: b_q <= mem_rdata;
               `SXL_SLOT_A: a_q <= mem_rdata;
               default: cc_q <= mem_rdata;
            endcase
         end
      end
   end

endmodule

/* File: hw/sxl_map.svh */
`ifndef SXL_MAP_SVH
`define SXL_MAP_SVH

// Register byte offsets
`define SXL_OFF_CMD 12'h000
`define SXL_OFF_STAT 12'h004
`define SXL_OFF_ACC 12'h008
`define SXL_OFF_IDX 12'h00C
`define SXL_OFF_STK 12'h010
`define SXL_OFF_PC 12'h014

// Command word fields
`define SXL_CMD_OP_LSB 0
`define SXL_CMD_OP_MSB 4
`define SXL_CMD_MODE_LSB 5
`define SXL_CMD_MODE_MSB 6
`define SXL_CMD_IMM_LSB 8
`define SXL_CMD_IMM_MSB 15
`define SXL_CMD_EXT_LSB 16
`define SXL_CMD_EXT_MSB 31

// Condition code bit positions
`define SXL_CC_E 7
`define SXL_CC_F 6
`define SXL_CC_H 5
`define SXL_CC_I 4
`define SXL_CC_N 3
`define SXL_CC_Z 2
`define SXL_CC_V 1
`define SXL_CC_C 0

// Reset values
`define SXL_RST_CC 8'h50
`define SXL_RST_BYTE 8'h00
`define SXL_RST_WORD 16'h0000

// Stack byte slots, in push order
`define SXL_SLOT_PCL 4'h0
`define SXL_SLOT_PCH 4'h1
`define SXL_SLOT_OSL 4'h2
`define SXL_SLOT_OSH 4'h3
`define SXL_SLOT_YL 4'h4
`define SXL_SLOT_YH 4'h5
`define SXL_SLOT_XL 4'h6
`define SXL_SLOT_XH 4'h7
`define SXL_SLOT_DP 4'h8
`define SXL_SLOT_B 4'h9
`define SXL_SLOT_A 4'hA
`define SXL_SLOT_CC 4'hB
`define SXL_SLOTS_ALL 12'hFFF
`define SXL_SLOTS_NO_CC 12'h7FF
`define SXL_SLOTS_PC 12'h003
`define SXL_SLOTS_CC 12'h800

`endif

/* File: hw/sxl_pkg.sv */
package sxl_pkg;

   typedef enum logic [4:0] {
      op_or_into_accumulator_a = 5'h00,
      op_or_into_accumulator_b = 5'h01,
      op_or_condition_codes = 5'h02,
      op_push_hardware_stack = 5'h03,
      op_push_second_stack = 5'h04,
      op_pull_hardware_stack = 5'h05,
      op_pull_second_stack = 5'h06,
      op_rotate_left_nine_bit_a = 5'h07,
      op_rotate_left_nine_bit_b = 5'h08,
      op_rotate_left_nine_bit_mem = 5'h09,
      op_rotate_right_nine_bit_a = 5'h0A,
      op_rotate_right_nine_bit_b = 5'h0B,
      op_rotate_right_nine_bit_mem = 5'h0C,
      op_return_from_interrupt = 5'h0D,
      op_exception_stack = 5'h0E
   } sxl_op_type;

   typedef enum logic [1:0] {
      mode_immediate = 2'h0,
      mode_direct = 2'h1,
      mode_indexed = 2'h2,
      mode_extended = 2'h3
   } sxl_mode_type;

   typedef enum logic [1:0] {
      st_idle,
      st_read,
      st_write,
      st_stack
   } sxl_state_type;

   typedef struct packed {
      logic req;
      logic we;
      logic [15:0] addr;
      logic [7:0] wdata;
   } sxl_mem_req_type;

   typedef struct packed {
      logic [7:0] value;
      logic [7:0] cc;
   } sxl_alu_out_type;

endpackage

/* File: hw/sxl_alu.sv */
`include "sxl_map.svh"

module sxl_alu (
   // Operation
   input sxl_pkg::sxl_op_type op,
   // Operands and flags
   input wire logic [7:0] opa,
   input wire logic [7:0] opb,
   input wire logic [7:0] cc,
   // Result and new flags
   output sxl_pkg::sxl_alu_out_type res
);

   always_comb begin
      res.value = opa | opb;
      res.cc = cc;
      case (op)
         sxl_pkg::op_or_into_accumulator_a, sxl_pkg::op_or_into_accumulator_b: begin
            res.value = opa | opb;
            res.cc[`SXL_CC_V] = 1'b0;
         end
         sxl_pkg::op_or_condition_codes: begin
            res.value = cc | opb;
         end
         sxl_pkg::op_rotate_left_nine_bit_a, sxl_pkg::op_rotate_left_nine_bit_b,
         sxl_pkg::op_rotate_left_nine_bit_mem: begin
            res.value = {opa[6:0], cc[`SXL_CC_C]};
            res.cc[`SXL_CC_C] = opa[7];
            res.cc[`SXL_CC_V] = opa[7] ^ opa[6];
         end
         sxl_pkg::op_rotate_right_nine_bit_a, sxl_pkg::op_rotate_right_nine_bit_b,
         sxl_pkg::op_rotate_right_nine_bit_mem: begin
            res.value = {cc[`SXL_CC_C], opa[7:1]};
            res.cc[`SXL_CC_C] = opa[0];
         end
         default: begin
            res.value = opa;
         end
      endcase
      if (op == sxl_pkg::op_or_condition_codes) begin
         res.cc = res.value;
      end else begin
         res.cc[`SXL_CC_N] = res.value[7];
         res.cc[`SXL_CC_Z] = (res.value == 8'h00);
      end
   end

endmodule

/* File: hw/sxl_slot_pick.sv */
module sxl_slot_pick #(
   parameter int SLOTS = 12
) (
   // Outstanding byte slots and direction
   input wire logic [SLOTS-1:0] pending,
   input wire logic pull,
   // Chosen slot
   output logic found,
   output logic [3:0] slot
);

   // Push takes the lowest slot first, pull the highest first
   always_comb begin
      found = |pending;
      slot = 4'h0;
      for (int i = SLOTS - 1; i >= 0; i--) begin
         if (!pull && pending[i]) begin
            slot = 4'(i);
         end
      end
      for (int i = 0; i < SLOTS; i++) begin
         if (pull && pending[i]) begin
            slot = 4'(i);
         end
      end
   end

endmodule

/* File: test/sxl_core_props.sv */
module sxl_core_props (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // Memory
   input sxl_pkg::sxl_mem_req_type mem_out,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   ready_track_a: assert property (pready == (psel && penable))
      else $error("pready not tied to access phase");
   err_phase_a: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access phase");
   req_hold_a: assert property (mem_out.req && !mem_ack |=> mem_out.req && $stable(mem_out))
      else $error("memory request changed before ack");
   req_drop_a: assert property (mem_out.req && mem_ack |=> !mem_out.req)
      else $error("memory request not released after ack");
   push_down_a: assert property (mem_out.req && mem_out.we && mem_ack ##1 !mem_out.req ##1 mem_out.req && mem_out.we
      |-> mem_out.addr == $past(mem_out.addr, 2) - 16'h0001) else $error("push address not decremented");
   pull_up_a: assert property (mem_out.req && !mem_out.we && mem_ack ##1 !mem_out.req ##1 mem_out.req && !mem_out.we
      |-> mem_out.addr == $past(mem_out.addr, 2) + 16'h0001) else $error("pull address not incremented");
   rmw_addr_a: assert property (mem_out.req && !mem_out.we && mem_ack ##1 !mem_out.req ##1 mem_out.req && mem_out.we
      |-> mem_out.addr == $past(mem_out.addr, 2)) else $error("rotate wrote another address");
   rot_data_a: assert property (mem_out.req && !mem_out.we && mem_ack ##1 !mem_out.req ##1 mem_out.req && mem_out.we
      |-> mem_out.wdata[7:1] == $past(mem_rdata[6:0], 2) || mem_out.wdata[6:0] == $past(mem_rdata[7:1], 2))
      else $error("rotate result not shifted operand");
endmodule

bind sxl_core sxl_core_props sxl_core_props_inst (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .mem_out(mem_out), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

/* File: test/sxl_mem_model.sv */
module sxl_mem_model (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Wait cycles before each answer
   input wire logic [1:0] stall,
   // Core memory port
   input sxl_pkg::sxl_mem_req_type mem_out,
   output logic [7:0] mem_rdata,
   output logic mem_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:65535];
   logic [1:0] wait_q;
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         mem_ack <= 1'b0;
         wait_q <= 2'h0;
         mem_rdata <= 8'hA5;
      end else if (mem_out.req && !mem_ack && wait_q == stall) begin
         mem_ack <= 1'b1;
         wait_q <= 2'h0;
         mem_rdata <= mem[mem_out.addr];
         if (mem_out.we)
            mem[mem_out.addr] <= mem_out.wdata;
      end else begin
         // Data line never keeps the last byte outside an answer
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_out.req && !mem_ack)
            wait_q <= wait_q + 2'h1;
      end
   end
endmodule

/* File: test/sxl_core_bench.sv */
`include "sxl_map.svh"

module sxl_core_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, reset, psel, penable, pwrite, pready, pslverr, mem_ack, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [7:0] mem_rdata;
   logic [1:0] stall;
   sxl_pkg::sxl_mem_req_type mem_out;
   int err_count, checks_done, cycles, acks, base;
   logic [7:0] pb [12] = '{8'hEF, 8'hBE, 8'hCD, 8'hAB, 8'h78, 8'h56, 8'h34, 8'h12, 8'h12, 8'h00, 8'hC1, 8'h79};
   sxl_core sxl_core_inst (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mem_out(mem_out), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   sxl_mem_model sxl_mem_model_inst (.clk(clk), .reset(reset), .stall(stall), .mem_out(mem_out),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   task automatic end_of_test();
      if (err_count == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      checks_done++;
      if (s !== x) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
      apb(1'b0, a, 32'h0);
      chk(n, q, x);
   endtask
   task automatic run(input logic [4:0] op, input logic [1:0] md, input logic [7:0] imm, input logic [15:0] ext);
      apb(1'b1, `SXL_OFF_CMD, {ext, imm, 1'b0, md, op});
      do apb(1'b0, `SXL_OFF_STAT, 32'h0); while (q[0] !== 1'b0);
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (mem_ack)
         acks <= acks + 1;
      if (cycles == 20000) begin
         err_count++;
         end_of_test();
      end
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, stall} = '0;
      reset = 1'b1;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      sxl_mem_model_inst.mem[16'h1234] = 8'h00;
      sxl_mem_model_inst.mem[16'h2000] = 8'h40;
      sxl_mem_model_inst.mem[16'h1236] = 8'h41;
      {sxl_mem_model_inst.mem[16'hABCD], sxl_mem_model_inst.mem[16'hABCE]} = 16'h0112;
      sxl_mem_model_inst.mem[16'hABCF] = 8'h34;
      rd(`SXL_OFF_ACC, 32'h5000_0000, "reset acc");
      apb(1'b1, `SXL_OFF_ACC, 32'h2300_0080);
      run(sxl_pkg::op_or_into_accumulator_a, sxl_pkg::mode_immediate, 8'h01, 16'h0);
      rd(`SXL_OFF_ACC, 32'h2900_0081, "or imm");
      apb(1'b1, `SXL_OFF_ACC, 32'h2912_0081);
      run(sxl_pkg::op_or_into_accumulator_b, sxl_pkg::mode_direct, 8'h34, 16'h0);
      rd(`SXL_OFF_ACC, 32'h2512_0081, "or direct");
      run(sxl_pkg::op_or_into_accumulator_a, sxl_pkg::mode_extended, 8'h00, 16'h2000);
      rd(`SXL_OFF_ACC, 32'h2912_00C1, "or extended");
      run(sxl_pkg::op_or_condition_codes, sxl_pkg::mode_immediate, 8'h50, 16'h0);
      rd(`SXL_OFF_ACC, 32'h7912_00C1, "or codes");
      apb(1'b1, `SXL_OFF_STK, 32'h1000_ABCD);
      apb(1'b1, `SXL_OFF_IDX, 32'h5678_1234);
      apb(1'b1, `SXL_OFF_PC, 32'h0000_BEEF);
      stall <= 2'h2;
      base = acks;
      run(sxl_pkg::op_push_hardware_stack, sxl_pkg::mode_immediate, 8'hFF, 16'h0);
      chk("push accesses", acks - base, 12);
      foreach (pb[i]) chk("pushed byte", {24'h0, sxl_mem_model_inst.mem[16'h0FFF - i]}, {24'h0, pb[i]});
      rd(`SXL_OFF_STK, 32'h0FF4_ABCD, "push pointers");
      rd(`SXL_OFF_ACC, 32'h7912_00C1, "push flags");
      stall <= 2'h1;
      base = acks;
      run(sxl_pkg::op_push_hardware_stack, sxl_pkg::mode_immediate, 8'h00, 16'h0);
      chk("empty mask", acks - base, 0);
      apb(1'b1, `SXL_OFF_ACC, 32'h0);
      apb(1'b1, `SXL_OFF_IDX, 32'h0);
      apb(1'b1, `SXL_OFF_PC, 32'h0);
      apb(1'b1, `SXL_OFF_STK, 32'h0000_0FF4);
      run(sxl_pkg::op_pull_second_stack, sxl_pkg::mode_immediate, 8'hFF, 16'h0);
      rd(`SXL_OFF_ACC, 32'h7912_00C1, "pull acc");
      rd(`SXL_OFF_IDX, 32'h5678_1234, "pull idx");
      rd(`SXL_OFF_PC, 32'h0000_BEEF, "pull pc");
      rd(`SXL_OFF_STK, 32'hABCD_1000, "pull pointers");
      run(sxl_pkg::op_rotate_left_nine_bit_mem, sxl_pkg::mode_indexed, 8'h02, 16'h0);
      chk("rotated byte", {24'h0, sxl_mem_model_inst.mem[16'h1236]}, 32'h83);
      rd(`SXL_OFF_ACC, 32'h7A12_00C1, "rotate left flags");
      run(sxl_pkg::op_rotate_right_nine_bit_a, sxl_pkg::mode_immediate, 8'h00, 16'h0);
      rd(`SXL_OFF_ACC, 32'h7312_0060, "rotate right");
      apb(1'b1, `SXL_OFF_CMD, {24'h0, 3'h0, sxl_pkg::op_rotate_left_nine_bit_mem});
      chk("rotate imm refused", {31'h0, e}, 32'h1);
      apb(1'b0, 12'h018, 32'h0);
      chk("unmapped refused", {31'h0, e}, 32'h1);
      run(sxl_pkg::op_return_from_interrupt, sxl_pkg::mode_immediate, 8'h00, 16'h0);
      rd(`SXL_OFF_PC, 32'h0000_1234, "short return pc");
      rd(`SXL_OFF_STK, 32'hABD0_1000, "short return sp");
      rd(`SXL_OFF_ACC, 32'h0112_0060, "short return acc");
      run(sxl_pkg::op_exception_stack, sxl_pkg::mode_immediate, 8'h00, 16'h0);
      chk("stacked codes", {24'h0, sxl_mem_model_inst.mem[16'hABC4]}, 32'h81);
      apb(1'b1, `SXL_OFF_ACC, 32'h0);
      run(sxl_pkg::op_return_from_interrupt, sxl_pkg::mode_immediate, 8'h00, 16'h0);
      rd(`SXL_OFF_ACC, 32'h8112_0060, "full return acc");
      rd(`SXL_OFF_IDX, 32'h5678_1234, "full return idx");
      rd(`SXL_OFF_STK, 32'hABD0_1000, "full return sp");
      run(sxl_pkg::op_rotate_left_nine_bit_b, 2'h0, 8'h00, 16'h0);
      rd(`SXL_OFF_ACC, 32'h8012_0160, "rotate b");
      run(sxl_pkg::op_rotate_right_nine_bit_mem, 2'h3, 8'h00, 16'h1236);
      chk("ror byte", {24'h0, sxl_mem_model_inst.mem[16'h1236]}, 32'h41);
      run(sxl_pkg::op_push_second_stack, 2'h0, 8'h41, 16'h0);
      rd(`SXL_OFF_STK, 32'hABD0_0FFD, "second push sp");
      apb(1'b1, `SXL_OFF_STK, 32'h0FFD_0000);
      apb(1'b1, `SXL_OFF_ACC, 32'h0);
      run(sxl_pkg::op_pull_hardware_stack, 2'h0, 8'h41, 16'h0);
      rd(`SXL_OFF_STK, 32'h1000_ABD0, "hw pull sp");
      rd(`SXL_OFF_ACC, 32'h8100_0000, "hw pull acc");
      end_of_test();
   end
endmodule
